// File: src/cell_master_pkg.sv
package cell_master_pkg;

  // Widths and sizes of the port space and data paths
  localparam int PORT_W = 5;
  localparam int WORD_W = 32;
  localparam int LANE_W = 8;
  localparam int BUS_W = 16;

  // Mode input bit positions
  localparam int MODE_SINGLE_BIT = 0;
  localparam int MODE_AUX_BIT = 1;

  // Cell layout: 13 client words, 53 octet transfers or 27 halfword transfers
  localparam logic [3:0] CELL_LAST_WORD = 4'hC;
  localparam logic [5:0] XFERS_8 = 6'h35;
  localparam logic [5:0] XFERS_16 = 6'h1B;
  localparam logic [5:0] HEC_XFER_8 = 6'h04;
  localparam logic [5:0] HEC_XFER_16 = 6'h02;
  localparam logic [2:0] WORD_BYTES = 3'h4;

  // Receive path states
  typedef enum logic [1:0] {
    RX_POLL = 2'b00,
    RX_SELECT = 2'b01,
    RX_XFER = 2'b10
  } rx_state_e;

  // Transmit client handshake states
  typedef enum logic [1:0] {
    TX_ASK = 2'b00,
    TX_SELECT = 2'b01,
    TX_MOVE = 2'b10
  } tx_state_e;

  // Receive link pins, sampled together
  typedef struct packed {
    logic [15:0] data;
    logic soc;
    logic prty;
    logic [1:0] clav;
  } rx_pins_s;

  // Static configuration inputs
  typedef struct packed {
    logic [1:0] mode;
    logic wide;
    logic [4:0] count;
  } config_s;

  // Round-robin step; a count of zero means all 32 ports
  function automatic logic [4:0] next_port(input logic [4:0] idx, input logic [4:0] count);
    next_port = (idx >= count - 5'h01) ? 5'h00 : idx + 5'h01;
  endfunction

  // Pick the cell-available line that reports a given port
  function automatic logic clav_for(input logic [1:0] clav, input logic [4:0] port,
                                    input logic [1:0] mode);
    if (!mode[MODE_SINGLE_BIT] && mode[MODE_AUX_BIT] && port[0])
      clav_for = clav[1];
    else
      clav_for = clav[0];
  endfunction

endpackage

// File: src/xlat_table.sv
`timescale 1ns/1ps
`default_nettype none

// Logical to physical port table, one write port and two read ports
module xlat_table (
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [4:0] wr_index_in,
  input wire logic [4:0] wr_value_in,
  // Read ports
  input wire logic [4:0] tx_index_in,
  input wire logic [4:0] rx_index_in,
  output logic [4:0] tx_value_out,
  output logic [4:0] rx_value_out
);

  logic [4:0] table_mem [0:31];

  // Entries hold no reset value; software loads them before use
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      table_mem[wr_index_in] <= wr_value_in;
    end
  end

  // Reads are combinational, the caller registers the result
  assign tx_value_out = table_mem[tx_index_in];
  assign rx_value_out = table_mem[rx_index_in];

endmodule // xlat_table

`default_nettype wire

// File: src/cell_master.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: Client holds transmit valid high while its word is present.
// R2: Client's port-valid qualifies its next port number.
// R3: Client gives a five-bit logical port for the next transmit cell.
// R4: Port request output goes high when the next port is wanted.
// R5: Cell-available of each polled transmit port shows on a 32-bit vector.
// R6: Table of 32 five-bit entries is written by the write strobe.
// R7: Mode bit 0 high picks single-PHY, low picks multi-PHY.
// R8: Single-PHY mode bit 1: zero octet handshake, one cell handshake.
// R9: Multi-PHY mode bit 1: zero one cell-available line, one two lines.
// R10: Wide select picks a 16-bit bus, else 8-bit, for data and parity.
// R11: Port count sets how many ports are polled.
// R12: Total-cell tick pulses once per transmitted cell; here only a full 13-word cell pulses it.
// R13: Short-cell tick pulses once per runt transmit cell.
// R14: Low octet on bits 7:0, high octet on 15:8 in wide mode.
// R15: Receive enable driven low requests data; PHY drives after seeing it.
// R16: Odd parity over active receive lanes is checked.
// R17: Cell-available bit 0 alone, or even ports bit 0 and odd ports bit 1.
// R18: Five-bit receive address polls and selects PHYs.
// R19: PHY start-of-cell marks the first transfer of a cell.
// R20: Received cells go to the client as 32-bit words.
// R21: Client start-of-cell output marks the first word of a cell.
// R22: Transmit ready high while client data can be taken.
// R23: Client receive ready high while it can take data.
// R24: Receive valid high while a received word is on the output.
// R25: Logical ports pass through the table onto the address bus.
// R26: Both paths follow their link clocks; reset idles them, enables off.
// R27: Only ports below the count are polled, round robin with wrap.
module cell_master (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Configuration
  input wire logic [1:0] topology_select_in,
  input wire logic wide_bus_select_in,
  input wire logic [4:0] poll_port_count_in,
  input wire logic xlat_wr_en_in,
  input wire logic [4:0] xlat_index_in,
  input wire logic [4:0] xlat_wr_value_in,
  // Transmit client side
  input wire logic cl_tx_valid_in,
  input wire logic cl_tx_first_in,
  input wire logic cl_tx_port_valid_in,
  input wire logic [4:0] cl_tx_next_port_in,
  output logic cl_tx_port_request_out,
  output logic [31:0] cl_tx_poll_status_out,
  output logic cl_tx_ready_out,
  output logic tx_total_cell_tick_out,
  output logic tx_short_cell_tick_out,
  // Transmit link polling
  input wire logic tx_link_clk_in,
  input wire logic [1:0] tx_clav_in,
  output logic [4:0] tx_addr_out,
  // Receive link
  input wire logic rx_link_clk_in,
  input wire logic [15:0] rx_data_in,
  input wire logic rx_soc_in,
  input wire logic rx_prty_in,
  input wire logic [1:0] rx_clav_in,
  output logic rx_enb_n_out,
  output logic [4:0] rx_addr_out,
  // Receive client side
  input wire logic cl_rx_ready_in,
  output logic [31:0] cl_rx_word_out,
  output logic cl_rx_first_out,
  output logic cl_rx_valid_out,
  output logic rx_parity_error_out
);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic [2:0] tx_clk_s;
  logic [2:0] rx_clk_s;
  logic [1:0] tx_clav1, tx_clav2, tx_clav3;
  cell_master_pkg::rx_pins_s rx_p1, rx_p2, rx_p3;
  cell_master_pkg::config_s cfg1, cfg;
  logic tx_edge, rx_edge;

  cell_master_pkg::tx_state_e tx_state;
  logic [4:0] tx_port, tx_poll_idx, tx_polled, tx_polled_d, tx_rd_idx, tx_xlat;
  logic tx_polled_ok, tx_polled_ok_d, rx_polled_ok_d;
  logic [3:0] tx_word_cnt;

  cell_master_pkg::rx_state_e rx_state;
  logic [4:0] rx_poll_idx, rx_polled, rx_polled_d, rx_rd_idx, rx_xlat;
  logic rx_polled_ok, rx_hit, rx_pause, rx_enb_prev_low, rx_capture, rx_is_hec, rx_parity_ok;
  logic [5:0] rx_req_cnt, rx_rcv_cnt, rx_total, rx_pos;
  logic [31:0] rx_acc, next_acc;
  logic [2:0] rx_fill, rx_fill_base, next_fill;
  logic [3:0] rx_word_cnt, rx_word_base;

  // Link levels and the mode, width and count inputs pass two flops; link levels get a third stage for edge history
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_clk_s <= 3'h0;
      rx_clk_s <= 3'h0;
      tx_clav1 <= 2'h0;
      tx_clav2 <= 2'h0;
      tx_clav3 <= 2'h0;
      rx_p1 <= '0;
      rx_p2 <= '0;
      rx_p3 <= '0;
      cfg1 <= '0;
      cfg <= '0;
    end else begin
      tx_clk_s <= {tx_clk_s[1:0], tx_link_clk_in};
      rx_clk_s <= {rx_clk_s[1:0], rx_link_clk_in};
      tx_clav1 <= tx_clav_in;
      tx_clav2 <= tx_clav1;
      tx_clav3 <= tx_clav2;
      rx_p1 <= '{data: rx_data_in, soc: rx_soc_in, prty: rx_prty_in, clav: rx_clav_in};
      rx_p2 <= rx_p1;
      rx_p3 <= rx_p2;
      cfg1 <= '{mode: topology_select_in, wide: wide_bus_select_in, count: poll_port_count_in};
      cfg <= cfg1;
    end
  end

  // R26: act on link edges; stage 3 still holds pre-edge pin values
  assign tx_edge = tx_clk_s[1] & ~tx_clk_s[2];
  assign rx_edge = rx_clk_s[1] & ~rx_clk_s[2];

  // R6: table write and lookups
  xlat_table xlat_table_inst (
    .clk_in(clk_in),
    .wr_en_in(xlat_wr_en_in),
    .wr_index_in(xlat_index_in),
    .wr_value_in(xlat_wr_value_in),
    .tx_index_in(tx_rd_idx),
    .rx_index_in(rx_rd_idx),
    .tx_value_out(tx_xlat),
    .rx_value_out(rx_xlat)
  );

  // R25: selection shows the chosen port, otherwise the poll pointer
  assign tx_rd_idx = (tx_state == cell_master_pkg::TX_SELECT) ? tx_port : tx_poll_idx;
  assign rx_rd_idx = rx_hit ? rx_polled_d : rx_poll_idx;

  // Transmit polling: the PHY samples an address at one link edge and answers at the
  // next, so status lands two link edges after its address was shown
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_addr_out <= 5'h00;
      tx_poll_idx <= 5'h00;
      tx_polled <= 5'h00;
      tx_polled_d <= 5'h00;
      tx_polled_ok <= 1'b0;
      tx_polled_ok_d <= 1'b0;
      cl_tx_poll_status_out <= 32'h00000000;
    end else if (tx_edge) begin
      // R5 R9: one status bit per logical port, R17 picks the line
      if (tx_polled_ok_d) begin
        cl_tx_poll_status_out[tx_polled_d] <=
          cell_master_pkg::clav_for(tx_clav3, tx_polled_d, cfg.mode);
      end
      tx_polled_d <= tx_polled;
      tx_polled_ok_d <= tx_polled_ok;
      tx_addr_out <= tx_xlat;
      if (tx_state == cell_master_pkg::TX_SELECT) begin
        tx_polled_ok <= 1'b0;
      end else begin
        tx_polled <= tx_poll_idx;
        // R11 R27: round robin below the count
        tx_poll_idx <= cell_master_pkg::next_port(tx_poll_idx, cfg.count);
        tx_polled_ok <= 1'b1;
      end
    end
  end

  // Transmit client handshake and cell statistics
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_state <= cell_master_pkg::TX_ASK;
      tx_port <= 5'h00;
      tx_word_cnt <= 4'h0;
      cl_tx_port_request_out <= 1'b0;
      cl_tx_ready_out <= 1'b0;
      tx_total_cell_tick_out <= 1'b0;
      tx_short_cell_tick_out <= 1'b0;
    end else begin
      tx_total_cell_tick_out <= 1'b0;
      tx_short_cell_tick_out <= 1'b0;
      unique case (tx_state)
        cell_master_pkg::TX_ASK: begin
          // R4: ask for a port; R2 the number counts only with port-valid
          cl_tx_port_request_out <= 1'b1;
          if (cl_tx_port_request_out && cl_tx_port_valid_in) begin
            tx_port <= cl_tx_next_port_in;
            cl_tx_port_request_out <= 1'b0;
            tx_state <= cell_master_pkg::TX_SELECT;
          end
        end
        cell_master_pkg::TX_SELECT: begin
          // R22: ready at the same link edge that puts the port address out
          if (tx_edge) begin
            cl_tx_ready_out <= 1'b1;
            tx_word_cnt <= 4'h0;
            tx_state <= cell_master_pkg::TX_MOVE;
          end
        end
        cell_master_pkg::TX_MOVE: begin
          if (cl_tx_ready_out && cl_tx_valid_in) begin
            if (cl_tx_first_in && tx_word_cnt != 4'h0) begin
              // R13: a new cell cut the last one short
              tx_short_cell_tick_out <= 1'b1;
              tx_word_cnt <= 4'h1;
            end else if (tx_word_cnt == cell_master_pkg::CELL_LAST_WORD) begin
              // R12: full cell taken
              tx_total_cell_tick_out <= 1'b1;
              cl_tx_ready_out <= 1'b0;
              tx_state <= cell_master_pkg::TX_ASK;
            end else begin
              tx_word_cnt <= tx_word_cnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // R17: cell available for the port polled two edges before; R23 client must be ready
  assign rx_hit = (rx_state == cell_master_pkg::RX_POLL) && rx_polled_ok_d && cl_rx_ready_in &&
                  cell_master_pkg::clav_for(rx_p3.clav, rx_polled_d, cfg.mode);
  // R8: octet handshake pauses on a dropped cell-available line
  assign rx_pause = cfg.mode[cell_master_pkg::MODE_SINGLE_BIT] &&
                    !cfg.mode[cell_master_pkg::MODE_AUX_BIT] && !rx_p3.clav[0];
  // R10: transfers per cell follow the bus width
  assign rx_total = cfg.wide ? cell_master_pkg::XFERS_16 : cell_master_pkg::XFERS_8;
  assign rx_capture = rx_edge && (rx_state == cell_master_pkg::RX_XFER) && rx_enb_prev_low;
  // R19: start of cell resynchronises the transfer position
  assign rx_pos = rx_p3.soc ? 6'h00 : rx_rcv_cnt;
  assign rx_is_hec = rx_pos == (cfg.wide ? cell_master_pkg::HEC_XFER_16
                                         : cell_master_pkg::HEC_XFER_8);
  // R16: odd parity over active lanes gives an odd count of ones
  assign rx_parity_ok = cfg.wide ? ^{rx_p3.data, rx_p3.prty} : ^{rx_p3.data[7:0], rx_p3.prty};

  // Receive polling, selection and enable
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_state <= cell_master_pkg::RX_POLL;
      rx_enb_n_out <= 1'b1;
      rx_addr_out <= 5'h00;
      rx_poll_idx <= 5'h00;
      rx_polled <= 5'h00;
      rx_polled_ok <= 1'b0;
      rx_polled_d <= 5'h00;
      rx_polled_ok_d <= 1'b0;
      rx_req_cnt <= 6'h00;
      rx_rcv_cnt <= 6'h00;
      rx_enb_prev_low <= 1'b0;
    end else if (rx_edge) begin
      rx_enb_prev_low <= ~rx_enb_n_out;
      unique case (rx_state)
        cell_master_pkg::RX_POLL: begin
          // R18: address drives both polling and selection
          rx_addr_out <= rx_xlat;
          rx_req_cnt <= 6'h00;
          rx_rcv_cnt <= 6'h00;
          if (rx_hit) begin
            rx_polled_ok <= 1'b0;
            rx_polled_ok_d <= 1'b0;
            // R7: single PHY needs no selection step
            if (cfg.mode[cell_master_pkg::MODE_SINGLE_BIT]) begin
              rx_enb_n_out <= 1'b0;
              rx_state <= cell_master_pkg::RX_XFER;
            end else begin
              rx_state <= cell_master_pkg::RX_SELECT;
            end
          end else begin
            // Answer at an edge belongs to the address shown two edges before
            rx_polled_d <= rx_polled;
            rx_polled_ok_d <= rx_polled_ok;
            rx_polled <= rx_poll_idx;
            // R27: round robin below the count
            rx_poll_idx <= cell_master_pkg::next_port(rx_poll_idx, cfg.count);
            rx_polled_ok <= 1'b1;
          end
        end
        cell_master_pkg::RX_SELECT: begin
          // R15: address stood with enable high, now request data
          rx_enb_n_out <= 1'b0;
          rx_state <= cell_master_pkg::RX_XFER;
        end
        cell_master_pkg::RX_XFER: begin
          // One transfer is committed at each edge the enable is low
          if (!rx_enb_n_out) begin
            rx_req_cnt <= rx_req_cnt + 6'h01;
            if (rx_req_cnt + 6'h01 == rx_total || !cl_rx_ready_in || rx_pause) begin
              rx_enb_n_out <= 1'b1;
            end
          end else if (rx_req_cnt != rx_total && cl_rx_ready_in && !rx_pause) begin
            rx_enb_n_out <= 1'b0;
          end
          if (rx_capture) begin
            rx_rcv_cnt <= rx_pos + 6'h01;
            if (rx_pos + 6'h01 == rx_total) begin
              rx_enb_n_out <= 1'b1;
              rx_state <= cell_master_pkg::RX_POLL;
            end
          end
        end
        default: begin
          rx_enb_n_out <= 1'b1;
          rx_state <= cell_master_pkg::RX_POLL;
        end
      endcase
    end
  end

  // R14: first octet of a pair sits on the high lane
  assign rx_fill_base = rx_p3.soc ? 3'h0 : rx_fill;
  assign rx_word_base = rx_p3.soc ? 4'h0 : rx_word_cnt;
  assign next_acc = cfg.wide ? {rx_acc[15:0], rx_p3.data} : {rx_acc[23:0], rx_p3.data[7:0]};
  assign next_fill = rx_fill_base + (cfg.wide ? 3'h2 : 3'h1);

  // Word packing toward the client; the header check octet is dropped
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_acc <= 32'h00000000;
      rx_fill <= 3'h0;
      rx_word_cnt <= 4'h0;
      cl_rx_word_out <= 32'h00000000;
      cl_rx_first_out <= 1'b0;
      cl_rx_valid_out <= 1'b0;
      rx_parity_error_out <= 1'b0;
    end else begin
      cl_rx_valid_out <= 1'b0;
      cl_rx_first_out <= 1'b0;
      rx_parity_error_out <= 1'b0;
      if (rx_capture) begin
        // R16: flag a mismatch on each bad transfer
        rx_parity_error_out <= ~rx_parity_ok;
        if (!rx_is_hec) begin
          rx_acc <= next_acc;
          if (next_fill == cell_master_pkg::WORD_BYTES) begin
            // R20: full word out; R21 first word of cell; R24 valid with it
            cl_rx_word_out <= next_acc;
            cl_rx_valid_out <= 1'b1;
            cl_rx_first_out <= rx_word_base == 4'h0;
            rx_fill <= 3'h0;
            rx_word_cnt <= (rx_word_base == cell_master_pkg::CELL_LAST_WORD) ? 4'h0
                         : rx_word_base + 4'h1;
          end else begin
            rx_fill <= next_fill;
            rx_word_cnt <= rx_word_base;
          end
        end
      end
    end
  end

  // Checks on the handshakes, address translation and parity
  property p_rx_reset_idle;
    disable iff (1'b0) reset_in |=> rx_enb_n_out && !cl_tx_ready_out;
  endproperty
  a_rx_reset_idle: assert property (p_rx_reset_idle) else $error("enables not idle after reset"); // R26

  property p_tx_request_drop;
    cl_tx_port_request_out && cl_tx_port_valid_in |=> !cl_tx_port_request_out;
  endproperty
  a_tx_request_drop: assert property (p_tx_request_drop) else $error("port request stuck"); // R4

  property p_tx_ready_follows;
    cl_tx_port_request_out && cl_tx_port_valid_in |-> ##[1:20] cl_tx_ready_out;
  endproperty
  a_tx_ready_follows: assert property (p_tx_ready_follows) else $error("transmit ready late"); // R22

  property p_tx_total_ends;
    tx_total_cell_tick_out |-> !cl_tx_ready_out ##1 cl_tx_port_request_out;
  endproperty
  a_tx_total_ends: assert property (p_tx_total_ends) else $error("cell end mishandled"); // R12

  property p_tx_short;
    cl_tx_ready_out && cl_tx_valid_in && cl_tx_first_in && tx_word_cnt != 4'h0
      |=> tx_short_cell_tick_out && !tx_total_cell_tick_out;
  endproperty
  a_tx_short: assert property (p_tx_short) else $error("runt cell not counted"); // R13

  property p_rx_addr_xlat;
    rx_edge && rx_state == cell_master_pkg::RX_POLL |=> rx_addr_out == $past(rx_xlat);
  endproperty
  a_rx_addr_xlat: assert property (p_rx_addr_xlat) else $error("address not translated"); // R25

  property p_rx_parity;
    rx_capture && !rx_parity_ok |=> rx_parity_error_out;
  endproperty
  a_rx_parity: assert property (p_rx_parity) else $error("parity error missed"); // R16

  property p_rx_first_valid;
    cl_rx_first_out |-> cl_rx_valid_out;
  endproperty
  a_rx_first_valid: assert property (p_rx_first_valid) else $error("first without valid"); // R21

  property p_rx_enb_xfer;
    !rx_enb_n_out |-> rx_state == cell_master_pkg::RX_XFER;
  endproperty
  a_rx_enb_xfer: assert property (p_rx_enb_xfer) else $error("enable low outside transfer"); // R15

  c_rx_first: cover property (cl_rx_first_out);
  c_tx_total: cover property (tx_total_cell_tick_out);
  c_tx_short: cover property (tx_short_cell_tick_out);
  c_rx_parity: cover property (rx_parity_error_out);

endmodule // cell_master

`default_nettype wire

// File: test/phy_model.sv
`timescale 1ns/1ps
`default_nettype none

// One PHY on the link: answers polls, sends whole cells when enabled
module phy_model #(
  parameter logic [4:0] RX_ADDR = 5'h0A,
  parameter logic [4:0] TX_ADDR = 5'h09
) (
  // Receive link
  input wire logic rx_link_clk_in,
  input wire logic rx_enb_n_in,
  input wire logic [4:0] rx_addr_in,
  output logic [15:0] rx_data_out,
  output logic rx_soc_out,
  output logic rx_prty_out,
  output logic [1:0] rx_clav_out,
  // Transmit polling
  input wire logic tx_link_clk_in,
  input wire logic [4:0] tx_addr_in,
  output logic [1:0] tx_clav_out,
  // Bench control
  input wire logic [3:0] cells_in,
  input wire logic bad_prty_in,
  input wire logic wide_in
);
  logic [5:0] pos;
  logic [5:0] last;
  logic [3:0] sent;
  logic [7:0] oct;
  logic [7:0] oct_hi;

  // No reset pin on a PHY, so start values are set here
  initial begin
    pos = 6'h00;
    sent = 4'h0;
    rx_data_out = 16'h0000;
    rx_soc_out = 1'b0;
    rx_prty_out = 1'b0;
    rx_clav_out = 2'h0;
    tx_clav_out = 2'h0;
  end

  // Octet n of a cell carries n ^ 5A; wide transfers carry octets 2p and 2p+1
  assign oct_hi = {1'b0, pos, 1'b0} ^ 8'h5A;
  assign oct = wide_in ? (oct_hi ^ 8'h01) : ({2'h0, pos} ^ 8'h5A);
  assign last = wide_in ? 6'h1A : 6'h34;

  // clav answers the address seen at the previous link edge
  always @(posedge rx_link_clk_in) begin
    rx_clav_out <= {1'b0, (rx_addr_in == RX_ADDR) && (sent < cells_in)};
  end

  // drive only after enable sampled low; else bus toggles
  always @(posedge rx_link_clk_in) begin
    if (!rx_enb_n_in && (sent < cells_in)) begin
      rx_data_out <= wide_in ? {oct_hi, oct} : {~oct, oct}; // Upper lane is junk in narrow mode
      rx_soc_out <= (pos == 6'h00);
      rx_prty_out <= ~^(wide_in ? {oct_hi, oct} : {8'h00, oct}) ^ bad_prty_in;
      pos <= (pos == last) ? 6'h00 : pos + 6'h01;
      if (pos == last) begin
        sent <= sent + 4'h1;
      end
    end else begin
      rx_data_out <= ~rx_data_out;
      rx_soc_out <= 1'b0;
      rx_prty_out <= ~rx_prty_out;
    end
  end

  // Transmit side reports room only at its own address
  always @(posedge tx_link_clk_in) begin
    tx_clav_out <= {1'b0, tx_addr_in == TX_ADDR};
  end
endmodule // phy_model

`default_nettype wire

// File: test/tb_cell_master.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_cell_master;
  logic clk_in = 1'b0, reset_in = 1'b1, tx_lk = 1'b0, rx_lk = 1'b0;
  logic xlat_wr_en_in = 1'b0, cl_tx_valid_in = 1'b0, cl_tx_first_in = 1'b0;
  // the client is always ready to take received words
  logic cl_tx_port_valid_in = 1'b0, cl_rx_ready_in = 1'b1, bad = 1'b0, wide_sel = 1'b0;
  logic [4:0] xlat_index_in = 5'h00, xlat_wr_value_in = 5'h00, cl_tx_next_port_in = 5'h00;
  logic [3:0] cells = 4'h0;
  logic [4:0] tx_addr, rx_addr, sel_addr;
  logic [15:0] rx_data;
  logic [1:0] tx_clav, rx_clav;
  logic rx_soc, rx_prty, rx_enb_n, req, ready, tot, shrt, rfirst, rvalid, perr;
  logic [31:0] status, rword;
  logic [31:0] rx_q[$];
  logic fq[$];
  int error_cnt = 0, n_checks = 0, tot_cnt = 0, short_cnt = 0, perr_cnt = 0;

  always #10 clk_in = ~clk_in;
  // Link clocks at 160 ns, phases unrelated to the system clock
  initial begin #33; forever #80 tx_lk = ~tx_lk; end
  initial begin #51; forever #80 rx_lk = ~rx_lk; end

  cell_master cell_master_inst (.clk_in(clk_in), .reset_in(reset_in),
    .topology_select_in(2'h0), .wide_bus_select_in(wide_sel), .poll_port_count_in(5'h04),
    .xlat_wr_en_in(xlat_wr_en_in), .xlat_index_in(xlat_index_in),
    .xlat_wr_value_in(xlat_wr_value_in), .cl_tx_valid_in(cl_tx_valid_in),
    .cl_tx_first_in(cl_tx_first_in), .cl_tx_port_valid_in(cl_tx_port_valid_in),
    .cl_tx_next_port_in(cl_tx_next_port_in), .cl_tx_port_request_out(req),
    .cl_tx_poll_status_out(status), .cl_tx_ready_out(ready), .tx_total_cell_tick_out(tot),
    .tx_short_cell_tick_out(shrt), .tx_link_clk_in(tx_lk), .tx_clav_in(tx_clav),
    .tx_addr_out(tx_addr), .rx_link_clk_in(rx_lk), .rx_data_in(rx_data),
    .rx_soc_in(rx_soc), .rx_prty_in(rx_prty), .rx_clav_in(rx_clav),
    .rx_enb_n_out(rx_enb_n), .rx_addr_out(rx_addr), .cl_rx_ready_in(cl_rx_ready_in),
    .cl_rx_word_out(rword), .cl_rx_first_out(rfirst), .cl_rx_valid_out(rvalid),
    .rx_parity_error_out(perr));

  phy_model phy_model_inst (.rx_link_clk_in(rx_lk), .rx_enb_n_in(rx_enb_n),
    .rx_addr_in(rx_addr), .rx_data_out(rx_data), .rx_soc_out(rx_soc),
    .rx_prty_out(rx_prty), .rx_clav_out(rx_clav), .tx_link_clk_in(tx_lk),
    .tx_addr_in(tx_addr), .tx_clav_out(tx_clav), .cells_in(cells), .bad_prty_in(bad),
    .wide_in(wide_sel));

  // Pulses are counted and words queued here so tasks judge the totals and each word afterwards
  always @(posedge clk_in) begin
    if (tot === 1'b1) tot_cnt++;
    if (shrt === 1'b1) short_cnt++;
    if (perr === 1'b1) perr_cnt++;
    if (rvalid === 1'b1) begin
      rx_q.push_back(rword);
      fq.push_back(rfirst);
      if (rfirst === 1'b1) sel_addr = rx_addr;
    end
  end

  function automatic logic [4:0] phys(input int i);
    return 5'(i + 8);
  endfunction

  // First kept octet lands in the top byte; the header check transfer is dropped
  function automatic logic [31:0] exp_word(input int k, input logic wd);
    int n;
    logic [31:0] w;
    w = 32'h0;
    for (int j = 0; j < 4; j++) begin
      n = 4 * k + j;
      n = (n < 4) ? n : n + (wd ? 2 : 1);
      w = {w[23:0], 8'(n) ^ 8'h5A};
    end
    return w;
  endfunction

  task automatic t_reset();
    repeat (11) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("enb_in_reset", 1'b1, rx_enb_n)
    `CHK("ready_in_reset", 1'b0, ready)
    @(posedge clk_in) reset_in <= 1'b0;
    repeat (2) @(negedge clk_in);
    `CHK("port_request", 1'b1, req)
  endtask

  task automatic t_table();
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_in);
      xlat_wr_en_in <= 1'b1;
      xlat_index_in <= 5'(i);
      xlat_wr_value_in <= phys(i);
    end
    @(posedge clk_in) xlat_wr_en_in <= 1'b0;
  endtask

  task automatic t_poll();
    repeat (300) @(negedge clk_in);
    `CHK("poll_status", 32'h0000_0002, status)
  endtask

  task automatic tx_port(input logic [4:0] p);
    int w;
    w = 0;
    do begin @(negedge clk_in); w++; end while (req !== 1'b1 && w < 400);
    @(posedge clk_in);
    cl_tx_port_valid_in <= 1'b1;
    cl_tx_next_port_in <= p;
    @(posedge clk_in) cl_tx_port_valid_in <= 1'b0;
    w = 0;
    do begin @(negedge clk_in); w++; end while (ready !== 1'b1 && w < 400);
    `CHK("req_dropped", 1'b0, req)
    `CHK("tx_addr", phys(p), tx_addr)
  endtask

  task automatic tx_words(input int n, input int k);
    int w;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      cl_tx_valid_in <= 1'b1;
      cl_tx_first_in <= (i == 0) || (i == k);
      w = 0;
      do begin @(negedge clk_in); w++; end while (ready !== 1'b1 && w < 400);
    end
    @(posedge clk_in);
    cl_tx_valid_in <= 1'b0;
    cl_tx_first_in <= 1'b0;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic t_tx_full();
    tx_port(5'h03);
    tx_words(13, 0);
    `CHK("total_ticks", 1, tot_cnt)
    `CHK("short_ticks", 0, short_cnt)
    `CHK("ready_after_cell", 1'b0, ready)
  endtask

  // A start-of-cell mid cell marks a runt and restarts the word count
  task automatic t_tx_runt();
    tx_port(5'h00);
    tx_words(18, 5);
    `CHK("short_ticks", 1, short_cnt)
    `CHK("total_ticks", 2, tot_cnt)
  endtask

  task automatic t_rx(input logic [3:0] c, input logic b, input logic wd);
    int w;
    int nf;
    rx_q.delete();
    fq.delete();
    perr_cnt = 0;
    nf = 0;
    @(posedge clk_in);
    cells <= c;
    bad <= b;
    wide_sel <= wd;
    w = 0;
    do begin @(negedge clk_in); w++; end while (rx_q.size() < 13 && w < 5000);
    repeat (40) @(negedge clk_in);
    `CHK("rx_words", 13, rx_q.size())
    for (int k = 0; k < rx_q.size(); k++) begin
      `CHK("rx_word", exp_word(k, wd), rx_q[k])
      if (fq[k] === 1'b1) nf++;
    end
    `CHK("rx_first", 1'b1, fq[0])
    `CHK("rx_first_once", 1, nf)
    `CHK("rx_sel_addr", phys(2), sel_addr)
    `CHK("parity_errors", b ? (wd ? 27 : 53) : 0, perr_cnt)
    `CHK("enb_idle", 1'b1, rx_enb_n)
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Run takes about 2000 cycles; the limit of 20000 cycles leaves ample slack
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end

  // Entries 0 to 3 load while reset is held, so polling never meets an unwritten entry
  initial begin
    fork
      t_reset();
      t_table();
    join
    t_poll();
    t_tx_full();
    t_tx_runt();
    t_rx(4'h1, 1'b0, 1'b0);
    t_rx(4'h2, 1'b1, 1'b0);
    t_rx(4'h3, 1'b0, 1'b1);
    stop_test();
  end
endmodule // tb_cell_master

`default_nettype wire
